// *** common/cbm_pkg.sv ***
// Constants shared by the cyclic byte mapper and its testbench.
package cbm_pkg;
    // Cyclic frame formats selected by bits 1:0 of configuration register 0.
    localparam logic [1:0] FMT_BASIC = 2'h0;
    localparam logic [1:0] FMT_EXT12 = 2'h1;
    localparam logic [1:0] FMT_EXT32 = 2'h2;
    localparam logic [5:0] LEN_BASIC = 6'h06;
    localparam logic [5:0] LEN_EXT12 = 6'h0C;
    localparam logic [5:0] LEN_EXT32 = 6'h20;
    // Byte offsets of the 16-bit fields, high byte at the offset.
    localparam int OFS_CMD     = 0;
    localparam int OFS_FREF    = 2;
    localparam int OFS_AO      = 10;
    localparam int OFS_DO      = 14;
    localparam int OFS_STAT    = 0;
    localparam int OFS_SPEED   = 2;
    localparam int OFS_TORQ    = 4;
    localparam int OFS_CUR_B   = 4;
    localparam int OFS_FREFMON = 8;
    localparam int OFS_OFREQ   = 10;
    localparam int OFS_CUR_X   = 12;
    localparam int OFS_AI      = 14;
    // Message area: start byte, offsets inside it and the handshake byte index.
    localparam logic [4:0] MSG_BASE_EXT32 = 5'h10;
    localparam logic [4:0] MSG_BASE_EXT12 = 5'h04;
    localparam logic [4:0] MSG_FUNC       = 5'h00;
    localparam logic [4:0] MSG_ADDR       = 5'h01;
    localparam logic [4:0] MSG_CNT        = 5'h03;
    localparam logic [4:0] MSG_DATA       = 5'h04;
    localparam logic [4:0] HS_EXT32       = 5'h1F;
    localparam logic [4:0] HS_EXT12       = 5'h0B;
    // Pass-through function codes of the output terminals, and the V/f control method code.
    localparam logic [2:0] AO_PASS = 3'h0;
    localparam logic [3:0] DO_PASS = 4'hF;
    localparam logic [2:0] CMS_VF  = 3'h0;
    // Divide by ten as multiply and shift, exact for 16-bit operands.
    localparam logic [16:0] DIV10_MUL   = 17'h0CCCD;
    localparam int          DIV10_SHIFT = 19;
    // Register offsets and reset values.
    localparam logic [3:0]  REG_CFG0   = 4'h0;
    localparam logic [3:0]  REG_CFG1   = 4'h4;
    localparam logic [3:0]  REG_STATUS = 4'h8;
    localparam logic [31:0] CFG0_RST   = 32'h0000_0004;
    localparam logic [31:0] CFG1_RST   = 32'h0000_0001;
    typedef enum logic [1:0] {
        MSG_IDLE  = 2'b00,
        MSG_WAIT  = 2'b01,
        MSG_REPLY = 2'b11
    } cbm_msg_t;
endpackage : cbm_pkg

// *** tb/cbm_byte_mapper_assertions.sv ***
// Concurrent checks on the ports of the cyclic byte mapper.
`timescale 1ns/1ps
`default_nettype none
module cbm_byte_mapper_chk (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        rxValid,
    input wire logic        cmdStrobe,
    input wire logic [15:0] cmdWord,
    input wire logic [15:0] aoWord,
    input wire logic        msgStart,
    input wire logic [15:0] msgAddr,
    input wire logic [15:0] msgData0,
    input wire logic        txStart,
    input wire logic        txBusy,
    input wire logic        txValid,
    input wire logic        txReady,
    input wire logic [7:0]  txByte,
    input wire logic        txLast
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_rdIdle; !$past(regRd) |-> regRdata == 32'h0; endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data seen outside its slot");
    property p_pulse; cmdStrobe |=> !cmdStrobe; endproperty
    a_pulse: assert property (p_pulse)
        else $error("command strobe longer than one cycle");
    property p_commit; cmdStrobe |-> $past(rxValid, 2); endproperty
    a_commit: assert property (p_commit)
        else $error("command strobe not two cycles after a frame byte");
    property p_fields;
        !cmdStrobe |-> $stable(cmdWord) && $stable(aoWord);
    endproperty
    a_fields: assert property (p_fields)
        else $error("drive fields changed without a commit");
    property p_msgCommit; msgStart |-> cmdStrobe; endproperty
    a_msgCommit: assert property (p_msgCommit)
        else $error("message start outside a frame commit");
    property p_msgHold;
        !msgStart |-> $stable(msgAddr) && $stable(msgData0);
    endproperty
    a_msgHold: assert property (p_msgHold)
        else $error("message fields changed between requests");
    property p_txHold;
        txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast);
    endproperty
    a_txHold: assert property (p_txHold)
        else $error("reply byte dropped during a stall");
    property p_txBusy; $rose(txBusy) |-> $past(txStart); endproperty
    a_txBusy: assert property (p_txBusy)
        else $error("busy rose without a start");
    property p_txLat; txStart && !txBusy |-> ##[2:3] txValid; endproperty
    a_txLat: assert property (p_txLat)
        else $error("reply frame did not start in time");
    c_commit: cover property (cmdStrobe);
    c_msg: cover property (msgStart);
    c_last: cover property (txValid && txReady && txLast);
endmodule : cbm_byte_mapper_chk
bind cbm_byte_mapper cbm_byte_mapper_chk CHK (.*);
`default_nettype wire

// *** tb/cbm_byte_mapper_tb.sv ***
// Self-checking bench for the cyclic byte mapper.
`timescale 1ns/1ps
`default_nettype none
module cbm_byte_mapper_tb;
    import cbm_pkg::*;
    logic        clk_sys, rstn, clkEn, regWr, regRd, txStart, msgDone;
    logic        rxValid, rxFirst, txValid, txReady, txLast, txBusy;
    logic        cmdStrobe, aoPass, relayOut, ocaOut, ocbOut;
    logic        torqueValid, msgStart;
    logic [3:0]  regAddr;
    logic [31:0] regWdata, regRdata;
    logic [7:0]  rxByte, txByte, msgFunc, msgCount;
    logic [15:0] cmdWord, freqRefWord, aoWord, msgAddr;
    logic [15:0] msgData0, msgData1, msgData2, msgData3;
    logic [15:0] monStatus = 16'h0A0B, monSpeedHz = 16'h1388;
    logic [15:0] monSpeedPct = 16'h2710, monSpeedRpm = 16'h0708;
    logic [15:0] monOutFreq = 16'h1357, monTorque = 16'h0064;
    logic [15:0] monFreqRef = 16'h1770, monCurrent = 16'h04D2;
    logic [15:0] monAnalogIn = 16'h0200, rspAddr = 16'h7201;
    logic [7:0]  rspFunc = 8'h72, rspCount = 8'h7D;
    logic [15:0] rspData0 = 16'h7200, rspData1 = 16'h7201;
    logic [15:0] rspData2 = 16'h7202, rspData3 = 16'h7203;
    logic [7:0]  of [32];
    logic [7:0]  ex [32];
    int          failures = 0, total_checks = 0, cyc = 0;
    int          strobes = 0, starts = 0;
    cbm_byte_mapper DUT (.*);
    cbm_master_model MST (.*);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        strobes <= strobes + cmdStrobe;
        starts  <= starts + msgStart;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1 cmp(regRdata, e);
    endtask : rd
    task automatic put(ref logic [7:0] a [32], input int i,
                       input logic [15:0] v);
        a[i]     = v[15:8];
        a[i + 1] = v[7:0];
    endtask : put
    task automatic area(ref logic [7:0] a [32], input int b, input int nw,
                        input logic [7:0] k);
        a[b] = k;
        put(a, b + 1, {k, 8'h01});
        a[b + 3] = k ^ 8'h0F;
        for (int j = 0; j < nw; j++) put(a, b + 4 + 2 * j, {k, 8'(j)});
    endtask : area
    task automatic rx(input int len, input int ds, input int dm);
        int s0;
        int m0;
        s0 = strobes;
        m0 = starts;
        MST.send(of, len);
        repeat (4) @(posedge clk_sys);
        cmp(strobes - s0, ds);
        cmp(starts - m0, dm);
    endtask : rx
    task automatic done();
        @(posedge clk_sys);
        msgDone <= 1'b1;
        @(posedge clk_sys);
        msgDone <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : done
    task automatic txFrame(input int len);
        int f0;
        f0 = MST.frames;
        @(posedge clk_sys);
        txStart <= 1'b1;
        @(posedge clk_sys);
        txStart <= 1'b0;
        for (int i = 0; i < 300 && MST.frames == f0; i++) @(posedge clk_sys);
        #1 cmp(MST.gotLen, len);
        cmp(MST.frames - f0, 1);
        for (int i = 0; i < len; i++) cmp(MST.got[i], ex[i]);
    endtask : txFrame
    initial begin
        {rstn, regWr, regRd, txStart, msgDone} = 5'h00;
        clkEn    = 1'b1;
        regAddr  = 4'h0;
        regWdata = 32'h0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(REG_CFG0, CFG0_RST);
        rd(REG_CFG1, CFG1_RST);
        rd(4'hC, 32'h0);
        foreach (of[i]) of[i] = 8'hEE;
        put(of, OFS_CMD, 16'h1234);
        put(of, OFS_FREF, 16'h5678);
        rx(LEN_BASIC, 1, 0);
        cmp(cmdWord, 16'h1234);
        cmp(freqRefWord, 16'h5678);
        cmp(torqueValid, 1'b0);
        foreach (ex[i]) ex[i] = 8'h00;
        put(ex, OFS_STAT, monStatus);
        put(ex, OFS_SPEED, monOutFreq);
        put(ex, OFS_CUR_B, monCurrent);
        txFrame(LEN_BASIC);
        wr(REG_CFG1, 32'h000F_0F00);
        wr(REG_CFG0, 32'h0000_1026);
        put(of, OFS_CMD, 16'h4321);
        put(of, OFS_AO, 16'h0ABC);
        put(of, OFS_DO, 16'h0007);
        area(of, MSG_BASE_EXT32, 4, 8'h31);
        of[HS_EXT32] = 8'h5A;
        rx(LEN_EXT32, 1, 1);
        cmp({msgFunc, msgCount}, 16'h313E);
        cmp({msgAddr, msgData0}, 32'h3101_3100);
        cmp({msgData1, msgData3}, 32'h3101_3103);
        cmp(msgData2, 16'h3102);
        cmp(cmdWord, 16'h4321);
        cmp(aoWord, 16'h0ABC);
        cmp({aoPass, relayOut, ocaOut, ocbOut}, 4'hE);
        done();
        rd(REG_STATUS, 32'h005A_5A00);
        wr(REG_STATUS, 32'hFFFF_FFFF);
        rd(REG_STATUS, 32'h005A_5A00);
        put(ex, OFS_SPEED, monSpeedHz);
        put(ex, OFS_TORQ, monTorque);
        put(ex, OFS_FREFMON, monFreqRef);
        put(ex, OFS_OFREQ, monOutFreq);
        put(ex, OFS_CUR_X, 16'h007B);
        put(ex, OFS_AI, monAnalogIn);
        area(ex, MSG_BASE_EXT32, 4, 8'h72);
        ex[HS_EXT32] = 8'h5A;
        txFrame(LEN_EXT32);
        cmp(torqueValid, 1'b1);
        wr(REG_CFG0, 32'h0000_1006);
        put(ex, OFS_SPEED, 16'h0000);
        put(ex, OFS_TORQ, 16'h0000);
        txFrame(LEN_EXT32);
        cmp(torqueValid, 1'b0);
        wr(REG_CFG0, 32'h0000_0125);
        foreach (of[i]) of[i] = 8'hEE;
        put(of, OFS_CMD, 16'h2468);
        put(of, OFS_FREF, 16'h1357);
        area(of, MSG_BASE_EXT12, 1, 8'h31);
        of[HS_EXT12] = 8'h66;
        rx(LEN_EXT12, 1, 1);
        cmp({freqRefWord, msgData0}, 32'h1357_3100);
        done();
        foreach (ex[i]) ex[i] = 8'h00;
        put(ex, OFS_STAT, monStatus);
        put(ex, OFS_SPEED, monSpeedPct);
        area(ex, MSG_BASE_EXT12, 1, 8'h72);
        ex[HS_EXT12] = 8'h66;
        txFrame(LEN_EXT12);
        wr(REG_CFG0, 32'h0000_0225);
        put(ex, OFS_SPEED, monSpeedRpm);
        txFrame(LEN_EXT12);
        rx(LEN_EXT12, 1, 0);
        wr(REG_CFG0, 32'h0000_0121);
        clkEn <= 1'b0;
        wr(REG_CFG0, 32'h0000_0000);
        clkEn <= 1'b1;
        rd(REG_CFG0, 32'h0000_0121);
        put(of, OFS_CMD, 16'h9999);
        rx(LEN_EXT12, 0, 0);
        cmp(cmdWord, 16'h2468);
        finish_test();
    end
endmodule : cbm_byte_mapper_tb
`default_nettype wire

// *** tb/cbm_master_model.sv ***
// Bus master model: sends output frames and drains reply frames.
`timescale 1ns/1ps
`default_nettype none
module cbm_master_model (
    input  wire logic       clk_sys,
    output logic            rxValid,
    output logic            rxFirst,
    output logic [7:0]      rxByte,
    input  wire logic       txValid,
    output logic            txReady,
    input  wire logic [7:0] txByte,
    input  wire logic       txLast
);
    logic [7:0] got [32];
    int         n      = 0;
    int         gotLen = 0;
    int         frames = 0;
    initial begin
        rxValid = 1'b0;
        rxFirst = 1'b0;
        rxByte  = 8'h00;
        txReady = 1'b0;
    end
    // Ready toggles so the reply buffer fills and refuses in turn.
    always @(posedge clk_sys) begin
        txReady <= ~txReady;
        if (txValid && txReady) begin
            got[n] <= txByte;
            n      <= txLast ? 0 : n + 1;
            if (txLast) begin
                gotLen <= n + 1;
                frames <= frames + 1;
            end
        end
    end
    task automatic send(input logic [7:0] f [32], input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_sys);
            rxValid <= 1'b1;
            rxFirst <= (i == 0);
            rxByte  <= f[i];
        end
        @(posedge clk_sys);
        rxValid <= 1'b0;
        rxFirst <= 1'b0;
        // A released lane shows the inverse of its last value.
        rxByte  <= ~rxByte;
    endtask : send
endmodule : cbm_master_model
`default_nettype wire

// *** verilog/cbm_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module cbm_buf2 #(
    parameter int W = 9
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         clkEn,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    logic [W-1:0] mem_q [2];
    logic         wrPtr_q;
    logic         rdPtr_q;
    logic [1:0]   count_q;
    wire          push = inValid && inReady && clkEn;
    wire          pop  = outValid && outReady && clkEn;

    assign inReady  = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData  = mem_q[rdPtr_q];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wrPtr_q  <= 1'b0;
            rdPtr_q  <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wrPtr_q] <= inData;
                wrPtr_q        <= ~wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= ~rdPtr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule : cbm_buf2
`default_nettype wire

// *** verilog/cbm_byte_mapper.sv ***
// Cyclic fieldbus byte mapper between bus frames and drive fields.
`timescale 1ns/1ps
`default_nettype none
module cbm_byte_mapper
    import cbm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    input  wire logic        rxValid,
    input  wire logic        rxFirst,
    input  wire logic [7:0]  rxByte,
    input  wire logic        txStart,
    output logic             txValid,
    input  wire logic        txReady,
    output logic [7:0]       txByte,
    output logic             txLast,
    output logic             txBusy,
    output logic [15:0]      cmdWord,
    output logic [15:0]      freqRefWord,
    output logic             cmdStrobe,
    output logic [15:0]      aoWord,
    output logic             aoPass,
    output logic             relayOut,
    output logic             ocaOut,
    output logic             ocbOut,
    input  wire logic [15:0] monStatus,
    input  wire logic [15:0] monSpeedHz,
    input  wire logic [15:0] monSpeedPct,
    input  wire logic [15:0] monSpeedRpm,
    input  wire logic [15:0] monOutFreq,
    input  wire logic [15:0] monTorque,
    input  wire logic [15:0] monFreqRef,
    input  wire logic [15:0] monCurrent,
    input  wire logic [15:0] monAnalogIn,
    output logic             torqueValid,
    output logic             msgStart,
    output logic [7:0]       msgFunc,
    output logic [15:0]      msgAddr,
    output logic [7:0]       msgCount,
    output logic [15:0]      msgData0,
    output logic [15:0]      msgData1,
    output logic [15:0]      msgData2,
    output logic [15:0]      msgData3,
    input  wire logic        msgDone,
    input  wire logic [7:0]  rspFunc,
    input  wire logic [15:0] rspAddr,
    input  wire logic [7:0]  rspCount,
    input  wire logic [15:0] rspData0,
    input  wire logic [15:0] rspData1,
    input  wire logic [15:0] rspData2,
    input  wire logic [15:0] rspData3
);
    function automatic logic [5:0] frameLen(input logic [1:0] f);
        frameLen = (f == FMT_EXT32) ? LEN_EXT32 :
                   (f == FMT_EXT12) ? LEN_EXT12 : LEN_BASIC;
    endfunction : frameLen

    logic [31:0] cfg0_q;
    logic [31:0] cfg1_q;
    logic [31:0] regRdata_q;
    logic [7:0]  rxBuf_q [32];
    logic [4:0]  rxIdx_q;
    logic        commit_q;
    logic [7:0]  txFrame_q [32];
    logic [7:0]  txFrameD [32];
    logic        txActive_q;
    logic [4:0]  txIdx_q;
    cbm_msg_t    msgState_q;
    logic [7:0]  hsSeen_q;
    logic [7:0]  hsEcho_q;
    logic [7:0]  rspFunc_q;
    logic [15:0] rspAddr_q;
    logic [7:0]  rspCount_q;
    logic [15:0] rspData_q [4];

    // Configuration fields.
    wire [1:0] fmtSel               = cfg0_q[1:0];
    wire       cyclicFormatSelect   = cfg0_q[2];
    wire [2:0] controlMethodSelect  = cfg0_q[6:4];
    wire [1:0] displayScalingSelect = cfg0_q[9:8];
    wire       ratedLarge           = cfg0_q[12];
    wire [2:0] analogOutputFunctionSelect   = cfg1_q[2:0];
    wire [3:0] relayOutputFunctionSelect    = cfg1_q[11:8];
    wire [3:0] openCollectorAFunctionSelect = cfg1_q[19:16];
    wire [3:0] openCollectorBFunctionSelect = cfg1_q[27:24];

    wire       isExt32  = (fmtSel == FMT_EXT32);
    wire       isBasic  = (fmtSel == FMT_BASIC);
    wire       vfMode   = (controlMethodSelect == CMS_VF);
    wire       mapOn    = cyclicFormatSelect;
    wire [5:0] lenNow   = frameLen(fmtSel);
    wire [4:0] lastIdx  = 5'(lenNow - 6'h01);
    wire [4:0] msgBase  = isExt32 ? MSG_BASE_EXT32 : MSG_BASE_EXT12;
    wire [4:0] hsIdx    = isExt32 ? HS_EXT32 : HS_EXT12;
    wire [4:0] rxIdxNow = rxFirst ? 5'h00 : rxIdx_q;

    // Received words, high byte first.
    wire [15:0] rxCmdW  = {rxBuf_q[OFS_CMD], rxBuf_q[OFS_CMD+1]};
    wire [15:0] rxFrefW = {rxBuf_q[OFS_FREF], rxBuf_q[OFS_FREF+1]};
    wire [15:0] rxAoW   = {rxBuf_q[OFS_AO], rxBuf_q[OFS_AO+1]};
    wire [15:0] rxDoW   = {rxBuf_q[OFS_DO], rxBuf_q[OFS_DO+1]};
    wire [7:0]  rxHs    = rxBuf_q[hsIdx];
    wire        newMsg  = commit_q && !isBasic &&
                          (rxHs != hsSeen_q) && (msgState_q == MSG_IDLE);

    // Monitor words as they enter the reply frame.
    wire [15:0] speedScaled = (displayScalingSelect == 2'h0) ? monSpeedHz :
                              (displayScalingSelect == 2'h1) ? monSpeedPct :
                              monSpeedRpm;
    wire [15:0] speedField  = !vfMode ? speedScaled :
                              isExt32 ? 16'h0000 : monOutFreq;
    wire [32:0] curProduct  = monCurrent * DIV10_MUL;
    wire [15:0] curTenth    = 16'(curProduct >> DIV10_SHIFT);
    wire [15:0] curField    = ratedLarge ? curTenth : monCurrent;
    wire [15:0] torqField   = vfMode ? 16'h0000 : monTorque;

    // Reply frame contents, each word high byte at the lower index.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            txFrameD[i] = 8'h00;
        end
        if (mapOn) begin
            {txFrameD[OFS_STAT], txFrameD[OFS_STAT+1]}   = monStatus;
            {txFrameD[OFS_SPEED], txFrameD[OFS_SPEED+1]} = speedField;
            if (isBasic) begin
                {txFrameD[OFS_CUR_B], txFrameD[OFS_CUR_B+1]} = curField;
            end else begin
                txFrameD[msgBase+MSG_FUNC]   = rspFunc_q;
                txFrameD[msgBase+MSG_ADDR]   = rspAddr_q[15:8];
                txFrameD[msgBase+MSG_ADDR+1] = rspAddr_q[7:0];
                txFrameD[msgBase+MSG_CNT]    = rspCount_q;
                txFrameD[msgBase+MSG_DATA]   = rspData_q[0][15:8];
                txFrameD[msgBase+MSG_DATA+1] = rspData_q[0][7:0];
                txFrameD[hsIdx]              = hsEcho_q;
            end
            if (isExt32) begin
                {txFrameD[OFS_TORQ], txFrameD[OFS_TORQ+1]} = torqField;
                {txFrameD[OFS_FREFMON], txFrameD[OFS_FREFMON+1]} = monFreqRef;
                {txFrameD[OFS_OFREQ], txFrameD[OFS_OFREQ+1]} = monOutFreq;
                {txFrameD[OFS_CUR_X], txFrameD[OFS_CUR_X+1]} = curField;
                {txFrameD[OFS_AI], txFrameD[OFS_AI+1]} = monAnalogIn;
                for (int k = 1; k < 4; k++) begin
                    txFrameD[MSG_BASE_EXT32+MSG_DATA+5'(2*k)] =
                        rspData_q[k][15:8];
                    txFrameD[MSG_BASE_EXT32+MSG_DATA+5'(2*k+1)] =
                        rspData_q[k][7:0];
                end
            end
        end
    end

    // Register bus: decode and read selection.
    wire        wrCfg0 = regWr && (regAddr == REG_CFG0);
    wire        wrCfg1 = regWr && (regAddr == REG_CFG1);
    wire [31:0] statusW = {7'h00, txActive_q, hsEcho_q, hsSeen_q,
                           6'h00, msgState_q};
    wire [31:0] rdSel  = (regAddr == REG_CFG0)   ? cfg0_q :
                         (regAddr == REG_CFG1)   ? cfg1_q :
                         (regAddr == REG_STATUS) ? statusW : 32'h0000_0000;
    assign regRdata = regRdata_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg0_q     <= CFG0_RST;
            cfg1_q     <= CFG1_RST;
            regRdata_q <= 32'h0000_0000;
        end else if (clkEn) begin
            if (wrCfg0) begin
                cfg0_q <= regWdata;
            end
            if (wrCfg1) begin
                cfg1_q <= regWdata;
            end
            regRdata_q <= regRd ? rdSel : 32'h0000_0000;
        end
    end

    // Frame reception into a byte store; commit after the last byte.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 32; i++) begin
                rxBuf_q[i] <= 8'h00;
            end
            rxIdx_q  <= 5'h00;
            commit_q <= 1'b0;
        end else if (clkEn) begin
            commit_q <= 1'b0;
            if (rxValid) begin
                rxBuf_q[rxIdxNow] <= rxByte;
                rxIdx_q           <= rxIdxNow + 5'h01;
                commit_q          <= mapOn && (rxIdxNow == lastIdx);
            end
        end
    end

    // Drive command fields and output terminals.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmdWord     <= 16'h0000;
            freqRefWord <= 16'h0000;
            cmdStrobe   <= 1'b0;
            aoWord      <= 16'h0000;
            relayOut    <= 1'b0;
            ocaOut      <= 1'b0;
            ocbOut      <= 1'b0;
        end else if (clkEn) begin
            cmdStrobe <= commit_q;
            if (commit_q) begin
                cmdWord     <= rxCmdW;
                freqRefWord <= rxFrefW;
                if (isExt32) begin
                    if (aoPass) begin
                        aoWord <= rxAoW;
                    end
                    if (relayOutputFunctionSelect == DO_PASS) begin
                        relayOut <= rxDoW[0];
                    end
                    if (openCollectorAFunctionSelect == DO_PASS) begin
                        ocaOut <= rxDoW[1];
                    end
                    if (openCollectorBFunctionSelect == DO_PASS) begin
                        ocbOut <= rxDoW[2];
                    end
                end
            end
        end
    end
    assign aoPass      = (analogOutputFunctionSelect == AO_PASS);
    assign torqueValid = !vfMode;

    // Register message exchange with the drive, paced by the handshake.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msgState_q <= MSG_IDLE;
            hsSeen_q   <= 8'h00;
            hsEcho_q   <= 8'h00;
            msgStart   <= 1'b0;
            msgFunc    <= 8'h00;
            msgAddr    <= 16'h0000;
            msgCount   <= 8'h00;
            msgData0   <= 16'h0000;
            msgData1   <= 16'h0000;
            msgData2   <= 16'h0000;
            msgData3   <= 16'h0000;
            rspFunc_q  <= 8'h00;
            rspAddr_q  <= 16'h0000;
            rspCount_q <= 8'h00;
            for (int k = 0; k < 4; k++) begin
                rspData_q[k] <= 16'h0000;
            end
        end else if (clkEn) begin
            msgStart <= 1'b0;
            unique case (msgState_q)
                MSG_IDLE: begin
                    if (newMsg) begin
                        hsSeen_q   <= rxHs;
                        msgStart   <= 1'b1;
                        msgFunc    <= rxBuf_q[msgBase+MSG_FUNC];
                        msgAddr    <= {rxBuf_q[msgBase+MSG_ADDR],
                                       rxBuf_q[msgBase+MSG_ADDR+1]};
                        msgCount   <= rxBuf_q[msgBase+MSG_CNT];
                        msgData0   <= {rxBuf_q[msgBase+MSG_DATA],
                                       rxBuf_q[msgBase+MSG_DATA+1]};
                        msgData1   <= isExt32 ? {rxBuf_q[22], rxBuf_q[23]}
                                              : 16'h0000;
                        msgData2   <= isExt32 ? {rxBuf_q[24], rxBuf_q[25]}
                                              : 16'h0000;
                        msgData3   <= isExt32 ? {rxBuf_q[26], rxBuf_q[27]}
                                              : 16'h0000;
                        msgState_q <= MSG_WAIT;
                    end
                end
                MSG_WAIT: begin
                    if (msgDone) begin
                        rspFunc_q    <= rspFunc;
                        rspAddr_q    <= rspAddr;
                        rspCount_q   <= rspCount;
                        rspData_q[0] <= rspData0;
                        rspData_q[1] <= rspData1;
                        rspData_q[2] <= rspData2;
                        rspData_q[3] <= rspData3;
                        msgState_q   <= MSG_REPLY;
                    end
                end
                MSG_REPLY: begin
                    hsEcho_q   <= hsSeen_q;
                    msgState_q <= MSG_IDLE;
                end
                default: begin
                    msgState_q <= MSG_IDLE;
                end
            endcase
        end
    end

    // Reply frame: snapshot on start, then byte by byte into the buffer.
    wire        bufInReady;
    wire        pushByte = txActive_q && bufInReady;
    wire        lastByte = (txIdx_q == lastIdx);
    wire [8:0]  bufOut;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 32; i++) begin
                txFrame_q[i] <= 8'h00;
            end
            txActive_q <= 1'b0;
            txIdx_q    <= 5'h00;
        end else if (clkEn) begin
            if (txStart && !txActive_q) begin
                txFrame_q  <= txFrameD;
                txActive_q <= 1'b1;
                txIdx_q    <= 5'h00;
            end else if (pushByte) begin
                txIdx_q    <= txIdx_q + 5'h01;
                txActive_q <= !lastByte;
            end
        end
    end

    cbm_buf2 #(
        .W (9)
    ) uTxBuf (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .clkEn    (clkEn),
        .inValid  (txActive_q),
        .inReady  (bufInReady),
        .inData   ({lastByte, txFrame_q[txIdx_q]}),
        .outValid (txValid),
        .outReady (txReady),
        .outData  (bufOut)
    );
    assign txByte = bufOut[7:0];
    assign txLast = bufOut[8];
    assign txBusy = txActive_q;
endmodule : cbm_byte_mapper
`default_nettype wire
